//--- rtl/nvm_pp_pkg.sv
// Purpose: Shared constants and types of the parallel NVM programming port.
// Assumes: 100 MHz core clock; pins arrive asynchronously.
// Notes: Fuse and lock reset values stand in for the stored array contents.
package nvm_pp_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 3700000;
  localparam int ERASE_TIME_NS = 7500000;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYCLES =
    (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  // ****************************************************************
  // Memory geometry
  // ****************************************************************
  localparam int FLASH_AW = 15;
  localparam int FLASH_WORD_W = 7;
  localparam int EE_AW = 11;
  localparam int EE_WORD_W = 3;
  localparam logic [15:0] FLASH_ERASED = 16'hFFFF;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  localparam int FUSE_HI_PRESERVE_BIT = 3;

  // ****************************************************************
  // Action select and command codes
  // ****************************************************************
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EEPROM = 8'h03;

  // ****************************************************************
  // Fuse, lock and signature values
  // ****************************************************************
  localparam logic [7:0] FUSE_LO_RESET = 8'hE1;
  localparam logic [7:0] FUSE_HI_RESET = 8'h99;
  localparam logic [7:0] FUSE_EXT_RESET = 8'hFD;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [1:0] SIG_LAST = 2'h2;
  localparam logic [7:0] CAL_LAST = 8'h03;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_ERASE = 3'b001,
    OP_FLASH = 3'b010,
    OP_EEPROM = 3'b011,
    OP_FUSE = 3'b100,
    OP_LOCK = 3'b101
  } op_t;

  typedef struct packed {
    logic osc;
    logic act_hi;
    logic act_lo;
    logic sel_a;
    logic sel_b;
    logic page_latch_strobe;
    logic wr_n;
    logic oe_n;
    logic [7:0] data;
  } pin_t;

  localparam pin_t PIN_IDLE = '{wr_n: 1'b1, oe_n: 1'b1, default: '0};

  typedef struct packed {
    pin_t sync1;
    pin_t sync2;
    pin_t prev;
    logic [7:0] cmd;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] dat_lo;
    logic [7:0] dat_hi;
    logic busy;
    op_t op;
    logic [TIMER_W-1:0] timer;
    logic [FLASH_AW-1:0] walk;
    logic walk_done;
    logic [1:0] fuse_sel;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] fuse_ext;
    logic [7:0] lock;
    logic [7:0] rd_data;
    logic rd_en;
  } nvm_state_t;

endpackage

//--- rtl/nvm_parallel_port.sv
// Purpose: Parallel programming port of the on-chip Flash, EEPROM, fuses
//   and lock bits, as seen from inside the device.
// Assumes: All programmer pins are asynchronous and held for tens of ns,
//   so two synchroniser stages plus an edge register catch every pulse.
// Notes: The memory arrays live in this module; long busy times are
//   parameters so that a simulation can shorten them.
`timescale 1ns/10ps

module nvm_parallel_port
  import nvm_pp_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES,
  parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE1 = 8'hA5, // Arbitrary identity value.
  parameter logic [7:0] SIG_BYTE2 = 8'h3C, // Arbitrary identity value.
  parameter logic [7:0] CAL_BYTE0 = 8'h80,
  parameter logic [7:0] CAL_BYTE1 = 8'h81,
  parameter logic [7:0] CAL_BYTE2 = 8'h82,
  parameter logic [7:0] CAL_BYTE3 = 8'h83
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Programmer control pins
  input wire logic osc_in_strobe_i,
  input wire logic action_select_hi_i,
  input wire logic action_select_lo_i,
  input wire logic byte_select_a_i,
  input wire logic byte_select_b_i,
  input wire logic page_latch_strobe_i,
  input wire logic write_strobe_n_i,
  input wire logic output_enable_n_i,
  // Bidirectional byte bus
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Status
  output logic ready_flag_o
);

  // ****************************************************************
  // State and memories
  // ****************************************************************
  nvm_state_t st;
  nvm_state_t next_st;
  pin_t pins_in;
  pin_t pin;

  logic [15:0] flash_mem [0:(1<<FLASH_AW)-1];
  logic [7:0] eeprom_mem [0:(1<<EE_AW)-1];
  logic [15:0] flash_buf [0:(1<<FLASH_WORD_W)-1];
  logic [7:0] eeprom_buf [0:(1<<EE_WORD_W)-1];

  logic osc_rise;
  logic page_latch_strobe_rise;
  logic wr_fall;
  logic preserve_ee;
  logic walk_last;
  logic fl_we;
  logic [FLASH_AW-1:0] fl_addr;
  logic [15:0] fl_wdata;
  logic ee_we;
  logic [EE_AW-1:0] ee_addr;
  logic [7:0] ee_wdata;
  logic fb_we;
  logic eb_we;
  logic [FLASH_AW-1:0] fl_rd_addr;
  logic [EE_AW-1:0] ee_rd_addr;
  logic [7:0] flash_page;
  logic [7:0] eeprom_page;
  logic [15:0] fl_rd;
  logic [7:0] ee_rd;

  assign pins_in = '{
    osc: osc_in_strobe_i,
    act_hi: action_select_hi_i,
    act_lo: action_select_lo_i,
    sel_a: byte_select_a_i,
    sel_b: byte_select_b_i,
    page_latch_strobe: page_latch_strobe_i,
    wr_n: write_strobe_n_i,
    oe_n: output_enable_n_i,
    data: data_i
  };

  // Only the second stage and the edge register are read by logic.
  assign pin = st.sync2;
  assign osc_rise = pin.osc & ~st.prev.osc;
  assign page_latch_strobe_rise = pin.page_latch_strobe & ~st.prev.page_latch_strobe;
  assign wr_fall = ~pin.wr_n & st.prev.wr_n;

  // The preserve fuse acts as soon as it is programmed, not at a relatch.
  assign preserve_ee = ~st.fuse_hi[FUSE_HI_PRESERVE_BIT];

  // Word bits come from the low address, page bits straddle both bytes.
  assign fl_rd_addr = {st.addr_hi[6:0], st.addr_lo};
  assign ee_rd_addr = {st.addr_hi[2:0], st.addr_lo};
  assign flash_page = {st.addr_hi[6:0], st.addr_lo[7]};
  assign eeprom_page = {st.addr_hi[2:0], st.addr_lo[7:3]};
  assign fl_rd = flash_mem[fl_rd_addr];
  assign ee_rd = eeprom_mem[ee_rd_addr];

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st = st;
    fl_we = 1'b0;
    fl_addr = '0;
    fl_wdata = '0;
    ee_we = 1'b0;
    ee_addr = '0;
    ee_wdata = '0;
    fb_we = 1'b0;
    eb_we = 1'b0;
    walk_last = 1'b1;

    next_st.sync1 = pins_in;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;

    if (!st.busy) begin
      // Loads overwrite only their own byte; the rest stays for reuse.
      if (osc_rise) begin
        unique case ({pin.act_hi, pin.act_lo})
          ACT_ADDR: begin
            if (pin.sel_a) begin
              next_st.addr_hi = pin.data;
            end else begin
              next_st.addr_lo = pin.data;
            end
          end
          ACT_DATA: begin
            if (pin.sel_a) begin
              next_st.dat_hi = pin.data;
            end else begin
              next_st.dat_lo = pin.data;
            end
          end
          ACT_CMD: begin
            next_st.cmd = pin.data;
          end
          ACT_IDLE: begin
          end
        endcase
      end

      if (page_latch_strobe_rise && pin.sel_a) begin
        if (st.cmd == CMD_WR_FLASH) begin
          fb_we = 1'b1;
        end else if (st.cmd == CMD_WR_EEPROM) begin
          eb_we = 1'b1;
        end
      end

      // A no-op command falls through here, so no write can start.
      if (wr_fall) begin
        next_st.walk = '0;
        next_st.walk_done = 1'b0;
        next_st.timer = TIMER_W'(PROG_CYC);
        next_st.fuse_sel = {pin.sel_b, pin.sel_a};
        if (st.cmd == CMD_ERASE) begin
          next_st.busy = 1'b1;
          next_st.op = OP_ERASE;
          next_st.timer = TIMER_W'(ERASE_CYC);
        end else if (st.cmd == CMD_WR_FLASH && !pin.sel_a) begin
          next_st.busy = 1'b1;
          next_st.op = OP_FLASH;
        end else if (st.cmd == CMD_WR_EEPROM && !pin.sel_a) begin
          next_st.busy = 1'b1;
          next_st.op = OP_EEPROM;
        end else if (st.cmd == CMD_WR_FUSE) begin
          next_st.busy = 1'b1;
          next_st.op = OP_FUSE;
        end else if (st.cmd == CMD_WR_LOCK) begin
          next_st.busy = 1'b1;
          next_st.op = OP_LOCK;
        end
      end
    end else begin
      // The array walk runs beside the timer; busy ends when both are done.
      unique case (st.op)
        OP_ERASE: begin
          walk_last = &st.walk;
          fl_we = ~st.walk_done;
          fl_addr = st.walk;
          fl_wdata = FLASH_ERASED;
          ee_we = ~st.walk_done && ~preserve_ee &&
            (st.walk[FLASH_AW-1:EE_AW] == '0);
          ee_addr = st.walk[EE_AW-1:0];
          ee_wdata = BYTE_ERASED;
        end
        OP_FLASH: begin
          walk_last = &st.walk[FLASH_WORD_W-1:0];
          fl_we = ~st.walk_done;
          fl_addr = {flash_page, st.walk[FLASH_WORD_W-1:0]};
          fl_wdata = flash_buf[st.walk[FLASH_WORD_W-1:0]];
        end
        OP_EEPROM: begin
          walk_last = &st.walk[EE_WORD_W-1:0];
          ee_we = ~st.walk_done;
          ee_addr = {eeprom_page, st.walk[EE_WORD_W-1:0]};
          ee_wdata = eeprom_buf[st.walk[EE_WORD_W-1:0]];
        end
        OP_IDLE, OP_FUSE, OP_LOCK: begin
          walk_last = 1'b1;
        end
        default: begin
          walk_last = 1'b1;
        end
      endcase

      if (!st.walk_done) begin
        if (walk_last) begin
          next_st.walk_done = 1'b1;
        end else begin
          next_st.walk = st.walk + FLASH_AW'(1);
        end
      end

      if (st.timer != '0) begin
        next_st.timer = st.timer - TIMER_W'(1);
      end else if (st.walk_done) begin
        next_st.busy = 1'b0;
        next_st.op = OP_IDLE;
        unique case (st.op)
          OP_ERASE: begin
            // Locks open only after every Flash word has been erased.
            next_st.lock = LOCK_RESET;
          end
          OP_FUSE: begin
            if (st.fuse_sel[1]) begin
              next_st.fuse_ext = st.dat_lo;
            end else if (st.fuse_sel[0]) begin
              next_st.fuse_hi = st.dat_lo;
            end else begin
              next_st.fuse_lo = st.dat_lo;
            end
          end
          OP_LOCK: begin
            next_st.lock = st.lock & st.dat_lo;
          end
          OP_IDLE, OP_FLASH, OP_EEPROM: begin
          end
          default: begin
          end
        endcase
      end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    next_st.rd_en = ~pin.oe_n;
    next_st.rd_data = BYTE_ERASED;
    unique case (st.cmd)
      CMD_RD_FLASH: begin
        next_st.rd_data = pin.sel_a ? fl_rd[15:8] : fl_rd[7:0];
      end
      CMD_RD_EEPROM: begin
        if (!pin.sel_a) begin
          next_st.rd_data = ee_rd;
        end
      end
      CMD_RD_FUSE: begin
        unique case ({pin.sel_b, pin.sel_a})
          2'h0: next_st.rd_data = st.fuse_lo;
          2'h1: next_st.rd_data = st.lock;
          2'h2: next_st.rd_data = st.fuse_ext;
          2'h3: next_st.rd_data = st.fuse_hi;
        endcase
      end
      CMD_RD_SIG: begin
        if (!pin.sel_a) begin
          if (st.addr_lo[7:2] == '0 && st.addr_lo[1:0] <= SIG_LAST) begin
            unique case (st.addr_lo[1:0])
              2'h0: next_st.rd_data = SIG_BYTE0;
              2'h1: next_st.rd_data = SIG_BYTE1;
              default: next_st.rd_data = SIG_BYTE2;
            endcase
          end
        end else if (st.addr_lo <= CAL_LAST) begin
          unique case (st.addr_lo[1:0])
            2'h0: next_st.rd_data = CAL_BYTE0;
            2'h1: next_st.rd_data = CAL_BYTE1;
            2'h2: next_st.rd_data = CAL_BYTE2;
            2'h3: next_st.rd_data = CAL_BYTE3;
          endcase
        end
      end
      default: begin
        next_st.rd_data = BYTE_ERASED;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{
        sync1: PIN_IDLE,
        sync2: PIN_IDLE,
        prev: PIN_IDLE,
        cmd: CMD_NOP,
        op: OP_IDLE,
        fuse_lo: FUSE_LO_RESET,
        fuse_hi: FUSE_HI_RESET,
        fuse_ext: FUSE_EXT_RESET,
        lock: LOCK_RESET,
        rd_data: BYTE_ERASED,
        default: '0
      };
    end else begin
      st <= next_st;
    end
  end

  // Arrays carry no reset: their contents stand for non-volatile cells.
  always_ff @(posedge clk_i) begin
    if (fl_we) begin
      flash_mem[fl_addr] <= fl_wdata;
    end
    if (ee_we) begin
      eeprom_mem[ee_addr] <= ee_wdata;
    end
    if (fb_we) begin
      flash_buf[st.addr_lo[FLASH_WORD_W-1:0]] <= {st.dat_hi, st.dat_lo};
    end
    if (eb_we) begin
      eeprom_buf[st.addr_lo[EE_WORD_W-1:0]] <= st.dat_lo;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign data_o = st.rd_data;
  assign data_oe_o = st.rd_en;
  assign ready_flag_o = ~st.busy;

endmodule

//--- verif/nvm_pp_properties.sv
// Purpose: Port-level assertions for the parallel programming port.
// Assumes: Pins are held steady for several clocks around each strobe.
// Notes: Busy length is counted in helper logic, not by long repetition.
`timescale 1ns/10ps
module nvm_pp_properties
  import nvm_pp_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES,
  parameter int ERASE_CYC = ERASE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Programmer pins
  input wire logic osc_in_strobe_i,
  input wire logic action_select_hi_i,
  input wire logic action_select_lo_i,
  input wire logic byte_select_a_i,
  input wire logic byte_select_b_i,
  input wire logic page_latch_strobe_i,
  input wire logic write_strobe_n_i,
  input wire logic output_enable_n_i,
  input wire logic [7:0] data_i,
  // Device outputs
  input wire logic [7:0] data_o,
  input wire logic data_oe_o,
  input wire logic ready_flag_o
);
  // Wide enough that the full-length erase time never saturates it.
  logic [20:0] low_cnt;
  logic [15:0] pins;
  assign pins = {osc_in_strobe_i, action_select_hi_i, action_select_lo_i,
    byte_select_a_i, byte_select_b_i, page_latch_strobe_i,
    write_strobe_n_i, output_enable_n_i, data_i};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= '0;
    end else if (ready_flag_o) begin
      low_cnt <= '0;
    end else if (low_cnt != '1) begin
      low_cnt <= low_cnt + 21'h000001;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_READY_RESET: assert property ($rose(rst_n_i) |-> ready_flag_o)
    else $error("ready low right after reset");
  AST_OE_ON: assert property (
    (!output_enable_n_i)[*5] |-> data_oe_o)
    else $error("bus not driven with output enable low");
  AST_OE_OFF: assert property (
    output_enable_n_i[*5] |-> !data_oe_o)
    else $error("bus driven with output enable high");
  AST_READY_FALL: assert property (
    $fell(ready_flag_o) |-> !$past(write_strobe_n_i, 2))
    else $error("ready fell without a write strobe");
  AST_READY_HOLD: assert property (
    (ready_flag_o && write_strobe_n_i)[*6] |=> ready_flag_o)
    else $error("ready dropped while write strobe idle");
  AST_BUSY_MIN: assert property (
    $rose(ready_flag_o) |-> low_cnt >= PROG_CYC)
    else $error("busy shorter than programming time");
  AST_BUSY_MAX: assert property (
    low_cnt <= ERASE_CYC + 32776)
    else $error("busy longer than any operation");
  AST_DATA_STABLE: assert property (
    ($stable(pins) && ready_flag_o)[*8] |-> $stable(data_o))
    else $error("read data changed with pins idle");
  COV_BUSY: cover property ($fell(ready_flag_o));
  COV_DRIVE: cover property ($rose(data_oe_o));
  COV_ERASE: cover property (low_cnt == 21'h007530);
endmodule

bind nvm_parallel_port nvm_pp_properties #(
  .PROG_CYC(PROG_CYC),
  .ERASE_CYC(ERASE_CYC)
) u_props (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .osc_in_strobe_i(osc_in_strobe_i),
  .action_select_hi_i(action_select_hi_i),
  .action_select_lo_i(action_select_lo_i),
  .byte_select_a_i(byte_select_a_i),
  .byte_select_b_i(byte_select_b_i),
  .page_latch_strobe_i(page_latch_strobe_i),
  .write_strobe_n_i(write_strobe_n_i),
  .output_enable_n_i(output_enable_n_i),
  .data_i(data_i),
  .data_o(data_o),
  .data_oe_o(data_oe_o),
  .ready_flag_o(ready_flag_o)
);

//--- verif/nvm_programmer.sv
// Purpose: Behavioural parallel programmer driving the port's pins.
// Assumes: Osc and page latch strobes are held four clocks, the write strobe six, to pass the synchronisers.
// Notes: A released bus shows the inverse of its last driven value.
`timescale 1ns/10ps
module nvm_programmer
  import nvm_pp_pkg::*;
(
  // Clock and bus level
  input wire logic clk_i,
  input wire logic [7:0] bus_i,
  // Programmer pins
  output pin_t pin_o
);
  initial pin_o = PIN_IDLE;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic load(input logic [1:0] act, input logic sa,
                      input logic [7:0] v);
    pin_o.act_hi <= act[1];
    pin_o.act_lo <= act[0];
    pin_o.sel_a <= sa;
    pin_o.data <= v;
    tick(4);
    pin_o.osc <= 1'b1;
    tick(4);
    pin_o.osc <= 1'b0;
    tick(4);
  endtask
  task automatic latch();
    pin_o.sel_a <= 1'b1;
    tick(4);
    pin_o.page_latch_strobe <= 1'b1;
    tick(4);
    pin_o.page_latch_strobe <= 1'b0;
    tick(4);
  endtask
  task automatic write(input logic sa, input logic sb);
    pin_o.sel_a <= sa;
    pin_o.sel_b <= sb;
    tick(4);
    pin_o.wr_n <= 1'b0;
    tick(6);
    pin_o.wr_n <= 1'b1;
    tick(4);
  endtask
  task automatic read(input logic sa, input logic sb, output logic [7:0] v);
    pin_o.sel_a <= sa;
    pin_o.sel_b <= sb;
    pin_o.oe_n <= 1'b0;
    pin_o.data <= ~pin_o.data;
    tick(8);
    v = bus_i;
    pin_o.oe_n <= 1'b1;
    tick(4);
  endtask
endmodule

//--- verif/tb.sv
// Purpose: Self-checking bench for the parallel programming port.
// Assumes: Shortened busy times; each chip erase still walks the array.
// Notes: Erase runs first so that no read meets an unwritten word.
`timescale 1ns/10ps
module tb;
  import nvm_pp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  pin_t pin;
  logic [7:0] data_o;
  logic [7:0] bus;
  logic data_oe_o;
  logic ready_flag_o;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] sig [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hFF};
  logic [15:0] fw [2] = '{16'h1234, 16'hABCD};
  always #5 clk_i = ~clk_i;
  assign bus = data_oe_o ? data_o : pin.data;
  nvm_parallel_port #(.PROG_CYC(20), .ERASE_CYC(40)) dut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .osc_in_strobe_i(pin.osc),
    .action_select_hi_i(pin.act_hi),
    .action_select_lo_i(pin.act_lo),
    .byte_select_a_i(pin.sel_a),
    .byte_select_b_i(pin.sel_b),
    .page_latch_strobe_i(pin.page_latch_strobe),
    .write_strobe_n_i(pin.wr_n),
    .output_enable_n_i(pin.oe_n),
    .data_i(bus),
    .data_o(data_o),
    .data_oe_o(data_oe_o),
    .ready_flag_o(ready_flag_o)
  );
  nvm_programmer pgm (.clk_i(clk_i), .bus_i(bus), .pin_o(pin));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic sa, input logic sb, input logic [7:0] exp,
                    input string what);
    logic [7:0] v;
    pgm.read(sa, sb, v);
    chk(v, exp, what);
  endtask
  task automatic cmd(input logic [7:0] c);
    pgm.load(ACT_CMD, 1'b0, c);
  endtask
  // A stuck busy flag ends the run rather than hanging it.
  task automatic wait_rdy();
    int n;
    n = 0;
    while (ready_flag_o !== 1'b1 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 40000) begin
      bad_count++;
      $display("MISMATCH %0t ready timeout", $time);
      end_sim();
    end
  endtask
  task automatic op(input logic sa, input logic sb, input logic busy);
    pgm.write(sa, sb);
    chk({7'h00, ready_flag_o}, {7'h00, !busy}, "ready on write");
    wait_rdy();
  endtask
  task automatic fuses(input logic [7:0] lo, input logic [7:0] hi,
                       input logic [7:0] ext, input logic [7:0] lk);
    cmd(CMD_RD_FUSE);
    rd(1'b0, 1'b0, lo, "fuse low");
    rd(1'b1, 1'b1, hi, "fuse high");
    rd(1'b0, 1'b1, ext, "fuse ext");
    rd(1'b1, 1'b0, lk, "lock");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk({7'h00, ready_flag_o}, 8'h01, "ready at reset");
    chk({7'h00, data_oe_o}, 8'h00, "bus at reset");
    cmd(CMD_ERASE);
    op(1'b0, 1'b0, 1'b1);
    fuses(FUSE_LO_RESET, FUSE_HI_RESET, FUSE_EXT_RESET, LOCK_RESET);
    $display("test erase_and_fuses done");
    cmd(CMD_RD_SIG);
    for (int i = 0; i < 4; i++) begin
      pgm.load(ACT_ADDR, 1'b0, 8'(i));
      rd(1'b0, 1'b0, sig[i], "signature");
      rd(1'b1, 1'b0, 8'h80 + 8'(i), "calibration");
    end
    // The idle action code must leave both address and command alone.
    pgm.load(ACT_IDLE, 1'b0, 8'h00);
    rd(1'b1, 1'b0, 8'h83, "idle action");
    $display("test signature done");
    cmd(CMD_WR_FLASH);
    for (int w = 0; w < 2; w++) begin
      pgm.load(ACT_ADDR, 1'b0, 8'h80 + 8'(w));
      pgm.load(ACT_DATA, 1'b0, fw[w][7:0]);
      pgm.load(ACT_DATA, 1'b1, fw[w][15:8]);
      pgm.latch();
    end
    pgm.load(ACT_ADDR, 1'b1, 8'h01);
    pgm.write(1'b0, 1'b0);
    cmd(CMD_NOP);
    wait_rdy();
    op(1'b0, 1'b0, 1'b1);
    cmd(CMD_NOP);
    op(1'b0, 1'b0, 1'b0);
    cmd(CMD_RD_FLASH);
    for (int w = 0; w < 2; w++) begin
      pgm.load(ACT_ADDR, 1'b0, 8'h80 + 8'(w));
      rd(1'b0, 1'b0, fw[w][7:0], "flash low");
      rd(1'b1, 1'b0, fw[w][15:8], "flash high");
    end
    pgm.load(ACT_ADDR, 1'b0, 8'h00);
    rd(1'b0, 1'b0, 8'hFF, "other page");
    $display("test flash done");
    cmd(CMD_WR_EEPROM);
    pgm.load(ACT_ADDR, 1'b1, 8'h00);
    pgm.load(ACT_ADDR, 1'b0, 8'h08);
    pgm.load(ACT_DATA, 1'b0, 8'h5C);
    pgm.latch();
    op(1'b0, 1'b0, 1'b1);
    cmd(CMD_RD_EEPROM);
    rd(1'b0, 1'b0, 8'h5C, "eeprom");
    rd(1'b1, 1'b0, 8'hFF, "eeprom high");
    $display("test eeprom done");
    cmd(CMD_WR_FUSE);
    pgm.load(ACT_DATA, 1'b0, 8'hE0);
    op(1'b0, 1'b0, 1'b1);
    pgm.load(ACT_DATA, 1'b0, 8'hF7);
    op(1'b1, 1'b0, 1'b1);
    pgm.load(ACT_DATA, 1'b0, 8'hFC);
    op(1'b0, 1'b1, 1'b1);
    cmd(CMD_WR_LOCK);
    pgm.load(ACT_DATA, 1'b0, 8'hFC);
    op(1'b0, 1'b0, 1'b1);
    pgm.load(ACT_DATA, 1'b0, 8'hF3);
    op(1'b0, 1'b0, 1'b1);
    fuses(8'hE0, 8'hF7, 8'hFC, 8'hF0);
    $display("test fuse_lock done");
    cmd(CMD_ERASE);
    op(1'b0, 1'b0, 1'b1);
    fuses(8'hE0, 8'hF7, 8'hFC, 8'hFF);
    cmd(CMD_RD_FLASH);
    pgm.load(ACT_ADDR, 1'b1, 8'h01);
    pgm.load(ACT_ADDR, 1'b0, 8'h80);
    rd(1'b0, 1'b0, 8'hFF, "erased flash low");
    rd(1'b1, 1'b0, 8'hFF, "erased flash high");
    cmd(CMD_RD_EEPROM);
    pgm.load(ACT_ADDR, 1'b1, 8'h00);
    pgm.load(ACT_ADDR, 1'b0, 8'h08);
    rd(1'b0, 1'b0, 8'h5C, "preserved eeprom");
    $display("test preserve done");
    end_sim();
  end
endmodule
